// >>> core/mvic_regs.svh
// Register offsets, reset values and vector constants of the interrupt
// controller. Assumes a 32-bit AXI4-Lite register window of 4 words.
`ifndef MVIC_REGS_SVH
`define MVIC_REGS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define MVIC_OFF_FLAG 12'h000
`define MVIC_OFF_ENABLE 12'h004
`define MVIC_OFF_LEVEL 12'h008
`define MVIC_OFF_SERVICE 12'h00C

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MVIC_RST_FLAG 21'h000000
`define MVIC_RST_ENABLE 21'h000000
`define MVIC_RST_LEVEL 10'h000

// ----------------------------------------
// Service register fields
// ----------------------------------------
`define MVIC_SVC_ISR_LSB 0
`define MVIC_SVC_REQ_BIT 8
`define MVIC_SVC_LVL_LSB 12
`define MVIC_SVC_IDX_LSB 16

// ----------------------------------------
// Vector table
// ----------------------------------------
`define MVIC_VEC_BASE 20'h00003
`define MVIC_VEC_STEP 20'h00008
`define MVIC_RESP_OKAY 2'h0
`define MVIC_RESP_SLVERR 2'h2

// Source bits owned by each vector
`define MVIC_V0_SRC 21'h000001
`define MVIC_V1_SRC 21'h000002
`define MVIC_V2_SRC 21'h00001C
`define MVIC_V3_SRC 21'h0000E0
`define MVIC_V4_SRC 21'h000100
`define MVIC_V5_SRC 21'h000600
`define MVIC_V6_SRC 21'h001800
`define MVIC_V7_SRC 21'h006000
`define MVIC_V8_SRC 21'h0F8000
`define MVIC_V9_SRC 21'h100000

`endif

// >>> core/mvic_pkg.sv
// Types shared by the interrupt controller and its users.
// Assumes one system clock; constants live in mvic_regs.svh.
package mvic_pkg;

    typedef enum logic [1:0] {
        MVIC_LVL_NONE = 2'h0,
        MVIC_LVL_LOW = 2'h1,
        MVIC_LVL_HIGH = 2'h2,
        MVIC_LVL_TOP = 2'h3
    } mvic_lvl_t;

    // On-chip request sources, one cycle or level high
    typedef struct packed {
        logic timer_a_low_irq;
        logic timer_a_high_irq;
        logic timer_b_low_irq;
        logic timer_b_high_irq;
        logic base_timer_irq;
        logic sync_serial_irq;
        logic uart_rx_irq;
        logic async_sync_serial_irq;
        logic uart_tx_irq;
        logic adc_irq;
        logic timer_c_irq;
        logic timer_d_irq;
        logic pwm_chan_a_irq;
        logic pwm_chan_b_irq;
    } mvic_src_t;

    // Vector offered to the CPU core
    typedef struct packed {
        logic req;
        mvic_lvl_t lvl;
        logic [3:0] idx;
        logic [19:0] vec;
    } mvic_grant_t;

endpackage

// >>> core/mvic_ctrl.sv
// Multilevel vectored interrupt controller: 21 request flags, 10 vectors,
// three nesting levels, AXI4-Lite register slave.
// Assumes cpu_ack/cpu_ret come from the core on sys_clk; pins are async.
// Notes on behaviour
// - Three levels exist: top above high, high above low.
// - Requests at or below the level in service are refused.
// - Among pending vectors the highest level is granted.
// - At equal level the lowest vector address wins.
// - Twenty-odd sources merge onto ten vectors, 00003H upward in steps of 8.
// - Vectors three to ten take only high or low level.
`timescale 1ns/10ps
`include "mvic_regs.svh"
`default_nettype none

module mvic_ctrl
    import mvic_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ext_irq_a,
    input wire logic ext_irq_b,
    input wire logic ext_irq_c,
    input wire logic ext_irq_d,
    input wire logic ext_irq_e,
    input wire logic ext_irq_f,
    input wire logic port0_irq,
    input wire mvic_src_t src,
    input wire logic cpu_ack,
    input wire logic cpu_ret,
    output mvic_grant_t grant_r,
    output logic irq_r,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready_r,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready_r,
    output logic [1:0] bresp_r,
    output logic bvalid_r,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready_r,
    output logic [31:0] rdata_r,
    output logic [1:0] rresp_r,
    output logic rvalid_r,
    input wire logic rready
);

    localparam int NSRC = 21;
    localparam int NVEC = 10;
    localparam logic [NSRC-1:0] VEC_SRC [NVEC] = '{`MVIC_V0_SRC,
        `MVIC_V1_SRC, `MVIC_V2_SRC, `MVIC_V3_SRC, `MVIC_V4_SRC,
        `MVIC_V5_SRC, `MVIC_V6_SRC, `MVIC_V7_SRC, `MVIC_V8_SRC,
        `MVIC_V9_SRC};

    logic [6:0] pin_raw, pin_s1_r, pin_s2_r, pin_s3_r, pin_st_r, pin_st_nxt;
    logic [NSRC-1:0] ev, flag_r, flag_nxt, en_r, en_nxt;
    logic [NVEC-1:0] prio_r, prio_nxt, vreq;
    logic [2:0] isr_r, isr_nxt;
    mvic_lvl_t vlvl [NVEC];
    mvic_lvl_t cur_lvl, win_lvl;
    logic [3:0] win_idx;
    mvic_grant_t grant_nxt;
    logic irq_nxt, wr_go, rd_go, wr_hit, rd_hit;
    logic [31:0] wmask, rdata_nxt;
    logic awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
    logic [1:0] bresp_nxt, rresp_nxt;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // A pin level counts only once the second and third stages agree
    assign pin_raw = {port0_irq, ext_irq_f, ext_irq_d, ext_irq_e,
        ext_irq_c, ext_irq_b, ext_irq_a};

    always_comb begin
        pin_st_nxt = (pin_s2_r & pin_s3_r) |
            (pin_st_r & (pin_s2_r | pin_s3_r));
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pin_s1_r <= 7'h00;
            pin_s2_r <= 7'h00;
            pin_s3_r <= 7'h00;
            pin_st_r <= 7'h00;
        end else begin
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            pin_st_r <= pin_st_nxt;
        end
    end

    // ----------------------------------------
    // Source flags and registers
    // ----------------------------------------
    always_comb begin
        ev = '0;
        ev[0] = pin_st_nxt[0] & ~pin_st_r[0];
        ev[1] = pin_st_nxt[1] & ~pin_st_r[1];
        ev[2] = pin_st_nxt[2] & ~pin_st_r[2];
        ev[3] = src.timer_a_low_irq;
        ev[4] = pin_st_nxt[3] & ~pin_st_r[3];
        ev[5] = pin_st_nxt[4] & ~pin_st_r[4];
        ev[6] = pin_st_nxt[5] & ~pin_st_r[5];
        ev[7] = src.base_timer_irq;
        ev[8] = src.timer_a_high_irq;
        ev[9] = src.timer_b_low_irq;
        ev[10] = src.timer_b_high_irq;
        ev[11] = src.sync_serial_irq;
        ev[12] = src.uart_rx_irq;
        ev[13] = src.async_sync_serial_irq;
        ev[14] = src.uart_tx_irq;
        ev[15] = src.adc_irq;
        ev[16] = src.timer_c_irq;
        ev[17] = src.timer_d_irq;
        ev[18] = src.pwm_chan_a_irq;
        ev[19] = src.pwm_chan_b_irq;
        ev[20] = pin_st_nxt[6] & ~pin_st_r[6];
    end

    assign wr_go = awvalid & awready_r & wvalid & wready_r;
    assign rd_go = arvalid & arready_r;
    assign wmask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}},
        {8{wstrb[0]}}};

    always_comb begin
        flag_nxt = flag_r;
        en_nxt = en_r;
        prio_nxt = prio_r;
        if (wr_go && awaddr == `MVIC_OFF_FLAG) begin
            flag_nxt = flag_r & ~(wdata[NSRC-1:0] & wmask[NSRC-1:0]);
        end
        if (wr_go && awaddr == `MVIC_OFF_ENABLE) begin
            en_nxt = (en_r & ~wmask[NSRC-1:0]) |
                (wdata[NSRC-1:0] & wmask[NSRC-1:0]);
        end
        if (wr_go && awaddr == `MVIC_OFF_LEVEL) begin
            prio_nxt = (prio_r & ~wmask[NVEC-1:0]) |
                (wdata[NVEC-1:0] & wmask[NVEC-1:0]);
        end
        // A new event beats a clear in the same cycle
        flag_nxt = flag_nxt | ev;
        irq_nxt = |(flag_nxt & en_nxt);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            flag_r <= `MVIC_RST_FLAG;
            en_r <= `MVIC_RST_ENABLE;
            prio_r <= `MVIC_RST_LEVEL;
            irq_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
            en_r <= en_nxt;
            prio_r <= prio_nxt;
            irq_r <= irq_nxt;
        end
    end

    // ----------------------------------------
    // Nesting and arbitration
    // ----------------------------------------
    always_comb begin
        isr_nxt = isr_r;
        // Return is applied first so ret and ack may share a cycle
        if (cpu_ret) begin
            if (isr_r[2]) isr_nxt[2] = 1'b0;
            else if (isr_r[1]) isr_nxt[1] = 1'b0;
            else isr_nxt[0] = 1'b0;
        end
        if (cpu_ack && grant_r.req) begin
            unique case (grant_r.lvl)
                MVIC_LVL_TOP: isr_nxt[2] = 1'b1;
                MVIC_LVL_HIGH: isr_nxt[1] = 1'b1;
                default: isr_nxt[0] = 1'b1;
            endcase
        end
        if (isr_nxt[2]) cur_lvl = MVIC_LVL_TOP;
        else if (isr_nxt[1]) cur_lvl = MVIC_LVL_HIGH;
        else if (isr_nxt[0]) cur_lvl = MVIC_LVL_LOW;
        else cur_lvl = MVIC_LVL_NONE;
    end

    genvar gv;
    generate
        for (gv = 0; gv < NVEC; gv++) begin : g_vec
            assign vreq[gv] = |(flag_r & en_r & VEC_SRC[gv]);
            // First two vectors climb to top, the rest to high
            assign vlvl[gv] = !vreq[gv] ? MVIC_LVL_NONE :
                !prio_r[gv] ? MVIC_LVL_LOW :
                (gv < 2) ? MVIC_LVL_TOP : MVIC_LVL_HIGH;
        end
    endgenerate

    always_comb begin
        win_lvl = MVIC_LVL_NONE;
        win_idx = 4'h0;
        // Downward walk with >= leaves the lowest index on a tie
        for (int v = NVEC - 1; v >= 0; v--) begin
            if (vlvl[v] > cur_lvl && vlvl[v] >= win_lvl &&
                vlvl[v] != MVIC_LVL_NONE) begin
                win_lvl = vlvl[v];
                win_idx = 4'(v);
            end
        end
        grant_nxt.req = (win_lvl != MVIC_LVL_NONE);
        grant_nxt.lvl = win_lvl;
        grant_nxt.idx = win_idx;
        grant_nxt.vec = `MVIC_VEC_BASE + {13'h0000, win_idx, 3'h0};
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            isr_r <= 3'h0;
            grant_r <= '0;
        end else begin
            isr_r <= isr_nxt;
            grant_r <= grant_nxt;
        end
    end

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    assign wr_hit = awaddr == `MVIC_OFF_FLAG || awaddr == `MVIC_OFF_ENABLE ||
        awaddr == `MVIC_OFF_LEVEL || awaddr == `MVIC_OFF_SERVICE;
    assign rd_hit = araddr == `MVIC_OFF_FLAG || araddr == `MVIC_OFF_ENABLE ||
        araddr == `MVIC_OFF_LEVEL || araddr == `MVIC_OFF_SERVICE;

    always_comb begin
        // Address and data are taken together, one write in flight
        awready_nxt = awvalid & wvalid & ~awready_r & ~bvalid_r;
        wready_nxt = awready_nxt;
        bvalid_nxt = bvalid_r & ~bready;
        bresp_nxt = bresp_r;
        if (wr_go) begin
            bvalid_nxt = 1'b1;
            bresp_nxt = wr_hit ? `MVIC_RESP_OKAY : `MVIC_RESP_SLVERR;
        end
        arready_nxt = arvalid & ~arready_r & ~rvalid_r;
        rvalid_nxt = rvalid_r & ~rready;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (rd_go) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = rd_hit ? `MVIC_RESP_OKAY : `MVIC_RESP_SLVERR;
            rdata_nxt = 32'h00000000;
            if (araddr == `MVIC_OFF_FLAG) rdata_nxt[NSRC-1:0] = flag_r;
            if (araddr == `MVIC_OFF_ENABLE) rdata_nxt[NSRC-1:0] = en_r;
            if (araddr == `MVIC_OFF_LEVEL) rdata_nxt[NVEC-1:0] = prio_r;
            if (araddr == `MVIC_OFF_SERVICE) begin
                rdata_nxt[`MVIC_SVC_ISR_LSB +: 3] = isr_r;
                rdata_nxt[`MVIC_SVC_REQ_BIT] = grant_r.req;
                rdata_nxt[`MVIC_SVC_LVL_LSB +: 2] = grant_r.lvl;
                rdata_nxt[`MVIC_SVC_IDX_LSB +: 4] = grant_r.idx;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= 2'h0;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rresp_r <= 2'h0;
            rdata_r <= 32'h00000000;
        end else begin
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    mvic_lvl_t top_seen;
    logic [3:0] low_seen;
    logic [NVEC-1:0] vreq_q;

    always_comb begin
        top_seen = MVIC_LVL_NONE;
        low_seen = 4'h0;
        for (int v = 0; v < NVEC; v++) begin
            if (vlvl[v] > cur_lvl && vlvl[v] > top_seen) begin
                top_seen = vlvl[v];
                low_seen = 4'(v);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        vreq_q <= vreq;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_level_valid: assert property (grant_r.req |->
        grant_r.lvl != MVIC_LVL_NONE) else $error("grant without level");
    a_nest_refuse: assert property (grant_r.req |->
        (isr_r[2] == 1'b0) && !(isr_r[1] && grant_r.lvl != MVIC_LVL_TOP)
        && !(isr_r[0] && grant_r.lvl == MVIC_LVL_LOW))
        else $error("grant not above level in service");
    a_top_level: assert property ($past(top_seen) != MVIC_LVL_NONE
        |-> grant_r.req && grant_r.lvl == $past(top_seen))
        else $error("higher level vector not granted");
    a_low_index: assert property ($past(top_seen) != MVIC_LVL_NONE
        |-> grant_r.idx == $past(low_seen))
        else $error("tie not broken to lowest vector");
    a_vec_addr: assert property (grant_r.req |-> grant_r.vec ==
        `MVIC_VEC_BASE + 20'(grant_r.idx) * `MVIC_VEC_STEP)
        else $error("vector address wrong");
    a_ext_levels: assert property (grant_r.req && grant_r.idx < 4'h2
        |-> grant_r.lvl != MVIC_LVL_HIGH) else $error("ext vector at high");
    a_mid_levels: assert property (grant_r.req && grant_r.idx >= 4'h2
        |-> grant_r.lvl != MVIC_LVL_TOP) else $error("vector at top");
    a_shared_req: assert property (grant_r.req |->
        vreq_q[grant_r.idx]) else $error("grant for idle vector");
    a_ack_push: assert property (grant_r.req && cpu_ack && !cpu_ret
        |=> isr_r != 3'h0 ##0 !grant_r.req || grant_r.lvl > $past(grant_r.lvl))
        else $error("ack did not enter service");
    a_flag_sticky: assert property (ev[5] |=> flag_r[5][*2])
        else $error("flag lost after event");
    a_irq_level: assert property (##1 irq_r == $past(|(flag_nxt & en_nxt)))
        else $error("interrupt output wrong");

    c_nested: cover property (isr_r[0] ##[1:50] isr_r[0] && isr_r[1]);
    c_tie: cover property (vreq[2] && vreq[3] && vlvl[2] == vlvl[3]);
    c_shared: cover property (flag_r[15] && flag_r[16] && en_r[15]);
    c_top: cover property (grant_r.req && grant_r.lvl == MVIC_LVL_TOP);

endmodule

`default_nettype wire

// >>> testbench/mvic_cpu_model.sv
// CPU core model: takes the offered vector and leaves the level on command.
// Assumes grant_r from the controller and take/leave pulses from the bench.
`timescale 1ns/10ps
`default_nettype none

module mvic_cpu_model
    import mvic_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire mvic_grant_t grant_r,
    input wire logic take,
    input wire logic leave,
    input wire logic [1:0] dly,
    output logic cpu_ack,
    output logic cpu_ret,
    output logic [3:0] taken_idx
);
    logic pend_r;
    logic [1:0] cnt_r;

    // Acks only while an offer stands; dly gives a slow core
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pend_r <= 1'b0;
            cnt_r <= 2'h0;
            cpu_ack <= 1'b0;
            cpu_ret <= 1'b0;
            taken_idx <= 4'h0;
        end else begin
            cpu_ack <= 1'b0;
            cpu_ret <= leave;
            if (take) begin
                pend_r <= 1'b1;
            end
            if (pend_r && grant_r.req && !cpu_ack) begin
                if (cnt_r >= dly) begin
                    cpu_ack <= 1'b1;
                    taken_idx <= grant_r.idx;
                    pend_r <= 1'b0;
                    cnt_r <= 2'h0;
                end else begin
                    cnt_r <= cnt_r + 2'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> testbench/multilevel_vectored_interrupt_ctrl_tb.sv
// Self-checking bench of the interrupt controller over AXI4-Lite.
// Assumes the controller and the CPU core model on one 250 MHz clock.
`timescale 1ns/10ps
`include "mvic_regs.svh"
`default_nettype none

`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
    error_cnt++; $display("BAD %s exp %0h got %0h", n, e, g); end end

module multilevel_vectored_interrupt_ctrl_tb;
    import mvic_pkg::*;
    logic sys_clk = 1'b0, rst_n = 1'b0, cpu_ack, cpu_ret, irq_r;
    logic ea = 1'b0, eb = 1'b0, ec = 1'b0, ed = 1'b0, p0 = 1'b0;
    logic take = 1'b0, leave = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [1:0] dly = 2'h0, bresp_r, rresp_r, r;
    logic [3:0] taken_idx, wstrb = 4'hF;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata_r, d;
    mvic_src_t src_r = '0;
    mvic_grant_t grant_r;
    int error_cnt = 0, total_checks = 0;
    int fbit[10] = '{0, 1, 2, 5, 8, 9, 11, 13, 15, 20};

    always #2 sys_clk = ~sys_clk;

    mvic_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .ext_irq_a(ea),
        .ext_irq_b(eb), .ext_irq_c(ec), .ext_irq_d(ed), .ext_irq_e(1'b0),
        .ext_irq_f(1'b0), .port0_irq(p0), .src(src_r), .cpu_ack(cpu_ack),
        .cpu_ret(cpu_ret), .grant_r(grant_r), .irq_r(irq_r),
        .awaddr(awaddr), .awvalid(awvalid), .awready_r(awready_r),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready_r(wready_r),
        .bresp_r(bresp_r), .bvalid_r(bvalid_r), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready_r(arready_r),
        .rdata_r(rdata_r), .rresp_r(rresp_r), .rvalid_r(rvalid_r),
        .rready(rready));

    mvic_cpu_model cpu (.sys_clk(sys_clk), .rst_n(rst_n), .grant_r(grant_r),
        .take(take), .leave(leave), .dly(dly), .cpu_ack(cpu_ack),
        .cpu_ret(cpu_ret), .taken_idx(taken_idx));

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic got;
        got = 1'b0;
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1;
        bready <= 1'b1;
        while (!got) begin
            @(posedge sys_clk);
            if (awready_r) awvalid <= 1'b0;
            if (wready_r) wvalid <= 1'b0;
            if (bvalid_r) begin
                r = bresp_r; bready <= 1'b0; got = 1'b1;
            end
        end
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [11:0] a);
        logic got;
        got = 1'b0;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        while (!got) begin
            @(posedge sys_clk);
            if (arready_r) arvalid <= 1'b0;
            if (rvalid_r) begin
                d = rdata_r; r = rresp_r; rready <= 1'b0; got = 1'b1;
            end
        end
        @(posedge sys_clk);
    endtask

    task automatic drive(input int v, input logic b);
        case (v)
            0: ea <= b;
            1: eb <= b;
            2: ec <= b;
            3: ed <= b;
            4: src_r.timer_a_high_irq <= b;
            5: src_r.timer_b_low_irq <= b;
            6: src_r.sync_serial_irq <= b;
            7: src_r.async_sync_serial_irq <= b;
            8: src_r.adc_irq <= b;
            default: p0 <= b;
        endcase
    endtask

    // Pins pass a synchroniser, so the settle wait covers the slower path
    task automatic fire(input int v);
        drive(v, 1'b1);
        repeat (2) @(posedge sys_clk);
        drive(v, 1'b0);
        repeat (8) @(posedge sys_clk);
    endtask

    task automatic take_irq(input logic [1:0] dl, input logic [3:0] ex);
        int n;
        n = 0;
        dly <= dl; take <= 1'b1;
        @(posedge sys_clk);
        take <= 1'b0;
        while (!cpu_ack && n < 20) begin
            @(posedge sys_clk);
            n++;
        end
        `CHK("taken idx", ex, taken_idx)
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic leave_irq();
        leave <= 1'b1;
        @(posedge sys_clk);
        leave <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic t_reset();
        `CHK("req", 1'b0, grant_r.req)
        `CHK("irq", 1'b0, irq_r)
        rd(`MVIC_OFF_FLAG); `CHK("flag", 32'h0, d)
        rd(`MVIC_OFF_ENABLE); `CHK("enable", 32'h0, d)
        rd(`MVIC_OFF_LEVEL); `CHK("level", 32'h0, d)
        rd(12'h010); `CHK("rresp", `MVIC_RESP_SLVERR, r)
        `CHK("rdata", 32'h0, d)
        wr(12'h010, 32'hFFFF_FFFF); `CHK("bresp", `MVIC_RESP_SLVERR, r)
        $display("done reset");
    endtask

    task automatic t_vectors();
        wr(`MVIC_OFF_ENABLE, 32'h001F_FFFF);
        `CHK("bresp ok", `MVIC_RESP_OKAY, r)
        for (int v = 0; v < 10; v++) begin
            fire(v);
            `CHK("req", 1'b1, grant_r.req)
            `CHK("idx", v[3:0], grant_r.idx)
            `CHK("vec", 20'h00003 + 20'h00008 * v[19:0], grant_r.vec)
            `CHK("lvl", MVIC_LVL_LOW, grant_r.lvl)
            rd(`MVIC_OFF_FLAG); `CHK("flag", 32'h1 << fbit[v], d)
            wr(`MVIC_OFF_FLAG, 32'h1 << fbit[v]);
            repeat (3) @(posedge sys_clk);
            `CHK("req clr", 1'b0, grant_r.req)
            `CHK("irq clr", 1'b0, irq_r)
        end
        $display("done vectors");
    endtask

    task automatic t_mask();
        wr(`MVIC_OFF_ENABLE, 32'h0);
        fire(8);
        `CHK("irq masked", 1'b0, irq_r)
        `CHK("req masked", 1'b0, grant_r.req)
        wr(`MVIC_OFF_ENABLE, 32'h0000_8000);
        repeat (3) @(posedge sys_clk);
        `CHK("irq", 1'b1, irq_r)
        `CHK("idx", 4'h8, grant_r.idx)
        wr(`MVIC_OFF_FLAG, 32'h0000_8000);
        wr(`MVIC_OFF_ENABLE, 32'h001F_FFFF);
        $display("done mask");
    endtask

    task automatic t_prio();
        fire(5);
        fire(2);
        `CHK("idx tie", 4'h2, grant_r.idx)
        wr(`MVIC_OFF_LEVEL, 32'h20);
        repeat (3) @(posedge sys_clk);
        `CHK("idx high", 4'h5, grant_r.idx)
        `CHK("lvl high", MVIC_LVL_HIGH, grant_r.lvl)
        wr(`MVIC_OFF_LEVEL, 32'h61);
        fire(0);
        `CHK("idx top", 4'h0, grant_r.idx)
        `CHK("lvl top", MVIC_LVL_TOP, grant_r.lvl)
        take_irq(2'h0, 4'h0);
        `CHK("req nest", 1'b0, grant_r.req)
        // The top vector stays flagged until software clears it
        wr(`MVIC_OFF_FLAG, 32'h0000_0001);
        leave_irq();
        `CHK("idx back", 4'h5, grant_r.idx)
        take_irq(2'h3, 4'h5);
        rd(`MVIC_OFF_SERVICE); `CHK("svc isr", 3'h2, d[2:0])
        `CHK("svc rresp", `MVIC_RESP_OKAY, r)
        fire(6);
        `CHK("req same", 1'b0, grant_r.req)
        wr(`MVIC_OFF_FLAG, 32'h0000_0200);
        leave_irq();
        `CHK("idx next", 4'h6, grant_r.idx)
        wr(`MVIC_OFF_FLAG, 32'h001F_FFFF);
        $display("done priority");
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_vectors();
        t_mask();
        t_prio();
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        stop_test();
    end
endmodule
`default_nettype wire
